// ===== logic/frab_defines.svh
`ifndef FRAB_DEFINES_SVH
`define FRAB_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_WORKING   8'h00
`define OFS_STATUS    8'h04
`define OFS_PC_LATCH  8'h08
`define OFS_PC        8'h0C
`define OFS_FILE_IDX  8'h10
`define OFS_FILE_DATA 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define ZERO_BIT      0
`define LATCH_HI      6
`define LATCH_LO      3
`define LIT_HI        10

// ----------------------------------------
// reset values
// ----------------------------------------
`define WORKING_RST   8'h00
`define PC_LATCH_RST  7'h00
`define PC_RST        15'h0000
`define FILE_RST      8'h00

`endif

// ===== logic/frab_pkg.sv
`default_nettype none
package frab_pkg;

  // operation codes presented by the decoder
  typedef enum logic [3:0] {
    OP_NO_OPERATION        = 4'h0,
    OP_COMPLEMENT_FILE     = 4'h1,
    OP_CLEAR_FILE          = 4'h2,
    OP_CLEAR_WORKING       = 4'h3,
    OP_DECREMENT_FILE      = 4'h4,
    OP_DECREMENT_SKIP_ZERO = 4'h5,
    OP_INCREMENT_SKIP_ZERO = 4'h6,
    OP_UNCONDITIONAL_BRANCH = 4'h7
  } op_t;

  // execution sequencer, one-hot
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } seq_t;

endpackage
`default_nettype wire

// ===== logic/file_register_alu_and_branch.sv
// Operation
// - complement inverts every bit of the addressed file register, 7-bit address
// - destination bit zero writes working register, one writes back to file
// - clear file writes zeros to the file register and sets zero flag
// - clear working loads zeros into working register and sets zero flag
// - decrement subtracts one from file value, stored per destination bit
// - decrement-skip stores per destination, flags kept, zero result discards next
// - increment-skip stores per destination, flags kept, zero result discards next
// - branch loads the 11-bit literal into program counter bits 10..0
// - branch fills program counter bits 14..11 from high latch bits 6..3
// - branch takes two instruction cycles
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "frab_defines.svh"

module file_register_alu_and_branch
  import frab_pkg::*;
#(
  parameter int FILE_DEPTH = 128,
  parameter int ADDR_W     = 7
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // instruction issue from the decoder
  input  wire logic        instr_valid_i,
  input  wire logic [3:0]  instr_op_i,
  input  wire logic [ADDR_W-1:0] instr_addr_i,
  input  wire logic        instr_dest_i,
  input  wire logic [10:0] instr_lit_i,
  output logic             instr_ready_o,
  // core state
  output logic      [7:0]  w_o,
  output logic             zero_o,
  output logic      [14:0] pc_o,
  output logic             skip_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [FILE_DEPTH-1:0][7:0] file;
    logic [7:0]        w;
    logic              z;
    logic [14:0]       pc;
    logic [6:0]        latch;
    logic [ADDR_W-1:0] idx;
    logic              skip;
    seq_t              seq;
    logic              ready;
    logic              ack;
    logic [31:0]       rdata;
  } state_t;

  state_t     s_reg;
  state_t     s_next;
  op_t        op;
  logic       accept;
  logic       run;
  logic [7:0] operand;
  logic [7:0] result;
  logic       wb_req;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // register index: 0 means unmapped
  function automatic logic [2:0] decode_f(input logic [7:0] a);
    if (a == `OFS_WORKING) begin
      decode_f = 3'h1;
    end else if (a == `OFS_STATUS) begin
      decode_f = 3'h2;
    end else if (a == `OFS_PC_LATCH) begin
      decode_f = 3'h3;
    end else if (a == `OFS_PC) begin
      decode_f = 3'h4;
    end else if (a == `OFS_FILE_IDX) begin
      decode_f = 3'h5;
    end else if (a == `OFS_FILE_DATA) begin
      decode_f = 3'h6;
    end else begin
      decode_f = 3'h0;
    end
  endfunction

  // ----------------------------------------
  // operand path
  // ----------------------------------------
  // a waiting skip turns the next accepted word into a no_operation
  assign op      = op_t'(instr_op_i);
  assign accept  = instr_valid_i && s_reg.ready;
  assign run     = accept && !s_reg.skip;
  assign operand = s_reg.file[instr_addr_i];
  assign wb_req  = wb_cyc_i && wb_stb_i;

  // alu result
  always_comb begin
    case (op)
      OP_COMPLEMENT_FILE: result = ~operand;
      OP_DECREMENT_FILE,
      OP_DECREMENT_SKIP_ZERO: result = operand - 8'h01;
      OP_INCREMENT_SKIP_ZERO: result = operand + 8'h01;
      default: result = 8'h00;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    // bus: ack one cycle after the request, dropped the cycle after
    s_next.ack = wb_req && !s_reg.ack;
    if (wb_req && !s_reg.ack) begin
      case (decode_f(wb_adr_i))
        3'h1: s_next.rdata = {24'h000000, s_reg.w};
        3'h2: s_next.rdata = {31'h00000000, s_reg.z};
        3'h3: s_next.rdata = {25'h0000000, s_reg.latch};
        3'h4: s_next.rdata = {17'h00000, s_reg.pc};
        3'h5: s_next.rdata = {{(32-ADDR_W){1'b0}}, s_reg.idx};
        3'h6: s_next.rdata = {24'h000000, s_reg.file[s_reg.idx]};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    // writes land on the edge where the master sees ack
    if (wb_req && s_reg.ack && wb_we_i && wb_sel_i[0]) begin
      case (decode_f(wb_adr_i))
        3'h1: s_next.w = wb_dat_i[7:0];
        3'h2: s_next.z = wb_dat_i[`ZERO_BIT];
        3'h3: s_next.latch = wb_dat_i[6:0];
        3'h5: s_next.idx = wb_dat_i[ADDR_W-1:0];
        3'h6: s_next.file[s_reg.idx] = wb_dat_i[7:0];
        default: ;
      endcase
    end

    // flush slot after a branch, one lost cycle
    if (s_reg.seq == ST_FLUSH) begin
      s_next.seq   = ST_EXEC;
      s_next.ready = 1'b1;
    end

    // instruction wins over a bus write in the same cycle
    if (accept) begin
      s_next.pc   = s_reg.pc + 15'h0001;
      s_next.skip = 1'b0;
    end
    if (run) begin
      case (op)
        OP_COMPLEMENT_FILE, OP_DECREMENT_FILE: begin
          if (instr_dest_i) begin
            s_next.file[instr_addr_i] = result;
          end else begin
            s_next.w = result;
          end
          s_next.z = is_zero(result);
        end
        OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO: begin
          if (instr_dest_i) begin
            s_next.file[instr_addr_i] = result;
          end else begin
            s_next.w = result;
          end
          s_next.skip = is_zero(result);
        end
        OP_CLEAR_FILE: begin
          s_next.file[instr_addr_i] = `FILE_RST;
          s_next.z = 1'b1;
        end
        OP_CLEAR_WORKING: begin
          s_next.w = 8'h00;
          s_next.z = 1'b1;
        end
        OP_UNCONDITIONAL_BRANCH: begin
          s_next.pc = {s_reg.latch[`LATCH_HI:`LATCH_LO], instr_lit_i[`LIT_HI:0]};
          s_next.seq   = ST_FLUSH;
          s_next.ready = 1'b0;
        end
        default: ;
      endcase
    end

    // synchronous reset; the file contents are cleared too
    if (rst_i) begin
      s_next       = '0;
      s_next.w     = `WORKING_RST;
      s_next.latch = `PC_LATCH_RST;
      s_next.pc    = `PC_RST;
      s_next.seq   = ST_EXEC;
      s_next.ready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  // outputs straight from flops
  assign wb_dat_o      = s_reg.rdata;
  assign wb_ack_o      = s_reg.ack;
  assign instr_ready_o = s_reg.ready;
  assign w_o           = s_reg.w;
  assign zero_o        = s_reg.z;
  assign pc_o          = s_reg.pc;
  assign skip_o        = s_reg.skip;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic runs(input logic r, input op_t o, input op_t want);
    runs = r && (o == want);
  endfunction

  sequence s_flush;
    !instr_ready_o ##1 instr_ready_o;
  endsequence

  property p_complement;
    runs(run, op, OP_COMPLEMENT_FILE) && !instr_dest_i |=> w_o == ~$past(operand);
  endproperty
  a_complement: assert property (p_complement) else $error("complement result wrong");

  property p_dest_file;
    run && instr_dest_i && (op == OP_DECREMENT_FILE) |=>
      s_reg.file[$past(instr_addr_i)] == $past(operand) - 8'h01 && $stable(w_o);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination not honoured");

  property p_clear_file;
    runs(run, op, OP_CLEAR_FILE) |=> s_reg.file[$past(instr_addr_i)] == 8'h00 && zero_o;
  endproperty
  a_clear_file: assert property (p_clear_file) else $error("clear file failed");

  property p_clear_working;
    runs(run, op, OP_CLEAR_WORKING) |=> w_o == 8'h00 && zero_o;
  endproperty
  a_clear_working: assert property (p_clear_working) else $error("clear working failed");

  property p_decrement;
    runs(run, op, OP_DECREMENT_FILE) && !instr_dest_i |=> w_o == $past(operand) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("decrement result wrong");

  property p_dec_skip;
    runs(run, op, OP_DECREMENT_SKIP_ZERO) |=>
      $stable(zero_o) && (skip_o == ($past(operand) == 8'h01));
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

  property p_inc_skip;
    runs(run, op, OP_INCREMENT_SKIP_ZERO) |=>
      $stable(zero_o) && (skip_o == ($past(operand) == 8'hFF));
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");

  property p_discard;
    accept && skip_o |=> $stable(w_o) && $stable(zero_o) && !skip_o && pc_o == $past(pc_o) + 15'h0001;
  endproperty
  a_discard: assert property (p_discard) else $error("skipped word was executed");

  property p_branch_low;
    runs(run, op, OP_UNCONDITIONAL_BRANCH) |=> pc_o[10:0] == $past(instr_lit_i);
  endproperty
  a_branch_low: assert property (p_branch_low) else $error("branch low bits wrong");

  property p_branch_high;
    runs(run, op, OP_UNCONDITIONAL_BRANCH) |=> pc_o[14:11] == $past(s_reg.latch[6:3]);
  endproperty
  a_branch_high: assert property (p_branch_high) else $error("branch high bits wrong");

  property p_branch_cycles;
    runs(run, op, OP_UNCONDITIONAL_BRANCH) |=> s_flush;
  endproperty
  a_branch_cycles: assert property (p_branch_cycles) else $error("branch not two cycles");

  // expected flag worked out from the operand, not from the alu output
  property p_zero_flag;
    run && (op == OP_COMPLEMENT_FILE || op == OP_DECREMENT_FILE) |=>
      zero_o == (($past(op) == OP_COMPLEMENT_FILE) ? ($past(operand) == 8'hFF)
                                                   : ($past(operand) == 8'h01));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

endmodule

`default_nettype wire

// ===== bench/frab_decoder_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// decoder model
// ----------------------------------------
module frab_decoder_model (
  // clock
  input  wire logic        clk_i,
  // instruction handshake
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic      [3:0]  op_o,
  output logic      [6:0]  addr_o,
  output logic             dest_o,
  output logic      [10:0] lit_o
);
  // quiet at time zero
  initial begin
    valid_o = 1'b0;
    {op_o, addr_o, dest_o, lit_o} = '0;
  end
  // word held until the edge that sees ready
  task automatic issue(input logic [3:0] op, input logic [6:0] a, input logic d, input logic [10:0] k);
    valid_o <= 1'b1;
    {op_o, addr_o, dest_o, lit_o} <= {op, a, d, k};
    do @(posedge clk_i); while (ready_i !== 1'b1);
  endtask
  // idle fields flip so a stale word never passes
  task automatic idle();
    valid_o <= 1'b0;
    {op_o, addr_o, dest_o, lit_o} <= ~{op_o, addr_o, dest_o, lit_o};
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "frab_defines.svh"
module tb;
  import frab_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = '0;
  logic [3:0]  lanes = 4'h1;
  logic [7:0]  adr = '0;
  logic [31:0] dat = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        valid;
  logic [3:0]  op;
  logic [6:0]  addr;
  logic        dest;
  logic [10:0] lit;
  logic        ready;
  logic [7:0]  w;
  logic        zero;
  logic [14:0] pc;
  logic        skip;
  logic [14:0] exp_pc = '0;
  int          err_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // only lane 0 carries data; sel follows each request
  file_register_alu_and_branch u_file_register_alu_and_branch (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_valid_i(valid),
    .instr_op_i(op), .instr_addr_i(addr), .instr_dest_i(dest), .instr_lit_i(lit),
    .instr_ready_o(ready), .w_o(w), .zero_o(zero), .pc_o(pc), .skip_o(skip));
  frab_decoder_model u_frab_decoder_model (
    .clk_i(clk_i), .ready_i(ready), .valid_o(valid), .op_o(op), .addr_o(addr), .dest_o(dest),
    .lit_o(lit));
  // clock and hang guard
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle, held until ack is sampled
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, sel, adr, dat} <= {2'b11, wr, lanes, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic fset(input logic [6:0] i, input logic [7:0] v);
    wb(1'b1, `OFS_FILE_IDX, {25'h0, i});
    wb(1'b1, `OFS_FILE_DATA, {24'h0, v});
  endtask
  task automatic fchk(input logic [6:0] i, input logic [7:0] v);
    wb(1'b1, `OFS_FILE_IDX, {25'h0, i});
    wb(1'b0, `OFS_FILE_DATA, 32'h0);
    chk(q, {24'h0, v});
  endtask
  // every non-branch word advances pc
  task automatic run(input op_t o, input logic [6:0] a, input logic d);
    u_frab_decoder_model.issue(o, a, d, 11'h000);
    exp_pc = exp_pc + 15'h0001;
  endtask
  task automatic one(input op_t o, input logic [6:0] a, input logic d);
    @(posedge clk_i);
    run(o, a, d);
    u_frab_decoder_model.idle();
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_comp();
    fset(7'h05, 8'h5A);
    one(OP_COMPLEMENT_FILE, 7'h05, 1'b0);
    chk(w, 8'hA5);
    chk(zero, 1'b0);
    fchk(7'h05, 8'h5A);
    fset(7'h05, 8'hFF);
    one(OP_COMPLEMENT_FILE, 7'h05, 1'b1);
    chk(zero, 1'b1);
    fchk(7'h05, 8'h00);
  endtask
  task automatic t_clear();
    wb(1'b1, `OFS_WORKING, 32'h33);
    one(OP_CLEAR_WORKING, 7'h00, 1'b0);
    chk({zero, w}, 9'h100);
    fset(7'h7F, 8'h77);
    wb(1'b1, `OFS_STATUS, 32'h0);
    one(OP_CLEAR_FILE, 7'h7F, 1'b1);
    chk(zero, 1'b1);
    fchk(7'h7F, 8'h00);
  endtask
  task automatic t_dec();
    fset(7'h03, 8'h01);
    one(OP_DECREMENT_FILE, 7'h03, 1'b0);
    chk({zero, w}, 9'h100);
    fchk(7'h03, 8'h01);
    fset(7'h03, 8'h00);
    one(OP_DECREMENT_FILE, 7'h03, 1'b1);
    chk(zero, 1'b0);
    fchk(7'h03, 8'hFF);
  endtask
  task automatic t_skip();
    fset(7'h04, 8'h01);
    wb(1'b1, `OFS_WORKING, 32'h11);
    wb(1'b1, `OFS_STATUS, 32'h0);
    @(posedge clk_i);
    run(OP_DECREMENT_SKIP_ZERO, 7'h04, 1'b1);
    run(OP_CLEAR_WORKING, 7'h00, 1'b0);
    u_frab_decoder_model.idle();
    #1;
    chk({skip, zero, w}, 10'h011);
    chk(pc, exp_pc);
    fchk(7'h04, 8'h00);
    // non-zero result: no skip armed; increment of FF arms a skip that discards the next no_operation
    fset(7'h08, 8'h03);
    one(OP_DECREMENT_SKIP_ZERO, 7'h08, 1'b0);
    chk({skip, w}, 9'h002);
    fset(7'h06, 8'hFF);
    one(OP_INCREMENT_SKIP_ZERO, 7'h06, 1'b0);
    chk({skip, zero, w}, 10'h200);
    one(OP_NO_OPERATION, 7'h00, 1'b0);
    one(OP_INCREMENT_SKIP_ZERO, 7'h05, 1'b1);
    chk(skip, 1'b0);
    fchk(7'h05, 8'h01);
    chk(pc, exp_pc);
  endtask
  task automatic t_branch(input logic [6:0] lat, input logic [10:0] k, input logic [14:0] e);
    time t0;
    wb(1'b1, `OFS_PC_LATCH, {25'h0, lat});
    @(posedge clk_i);
    u_frab_decoder_model.issue(OP_UNCONDITIONAL_BRANCH, 7'h00, 1'b0, k);
    u_frab_decoder_model.idle();
    #1;
    chk(ready, 1'b0);
    chk(pc, e);
    @(posedge clk_i);
    #1;
    chk(ready, 1'b1);
    wb(1'b0, `OFS_PC, 32'h0);
    chk(q, {17'h0, e});
    // a word offered in the stall slot is held until the second edge
    @(posedge clk_i);
    u_frab_decoder_model.issue(OP_UNCONDITIONAL_BRANCH, 7'h00, 1'b0, k);
    t0 = $time;
    u_frab_decoder_model.issue(OP_NO_OPERATION, 7'h00, 1'b0, 11'h000);
    t0 = $time - t0;
    u_frab_decoder_model.idle();
    #1;
    chk(32'(t0), 32'd20);
    chk(pc, e + 15'h0001);
  endtask
  // write with lane 0 off is ignored
  task automatic t_lanes();
    wb(1'b1, `OFS_WORKING, 32'h5C);
    lanes = 4'hE;
    wb(1'b1, `OFS_WORKING, 32'hA3);
    lanes = 4'h1;
    wb(1'b0, `OFS_WORKING, 32'h0);
    chk(q, 32'h5C);
  endtask
  // mid-run reset clears file, working, flag, pc and latch
  task automatic t_reset();
    wb(1'b1, `OFS_WORKING, 32'h3C);
    wb(1'b1, `OFS_STATUS, 32'h1);
    fset(7'h09, 8'h66);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({skip, zero, ready, w}, 11'h100);
    chk(pc, 15'h0000);
    fchk(7'h09, 8'h00);
    wb(1'b0, `OFS_PC_LATCH, 32'h0);
    chk(q, 32'h0);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_comp();
    t_clear();
    t_dec();
    t_skip();
    t_branch(7'h5F, 11'h7FF, 15'h5FFF);
    t_branch(7'h28, 11'h123, 15'h2923);
    t_lanes();
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
